// File: logic/sva_defs.svh
/*
 Constants for the saturating vector arithmetic unit: size codes,
 element and register widths, register number width and reset values.
 Assumes it is included by bare name, from the package and the modules.
*/
`ifndef SVA_DEFS_SVH
`define SVA_DEFS_SVH

// Element size field codes
`define SVA_SIZE_B8 2'h0
`define SVA_SIZE_B16 2'h1
`define SVA_SIZE_B32 2'h2
`define SVA_SIZE_B64 2'h3

// Element width is this base shifted left by the size code
`define SVA_ESIZE_BASE 8
// One 64-bit register and one 128-bit register pair
`define SVA_DREG_W 64
`define SVA_QREG_W 128
// Register number: high extension bit joined to the four-bit field
`define SVA_REG_NUM_W 5

// Reset values
`define SVA_STATE_RST 3'h1
`define SVA_FLAG_RST 1'h0

`endif

// File: logic/sva_pkg.sv
/*
 Types of the saturating vector arithmetic unit: operation select,
 one-hot sequencer states and the packed state record of the top module.
 Assumes sva_defs.svh is on the include path.
*/
`default_nettype none
`include "sva_defs.svh"

package sva_pkg;

    // Operation handed over by instruction decode
    typedef enum logic [1:0] {
        SVA_OP_ABS = 2'h0,
        SVA_OP_ADD = 2'h1,
        SVA_OP_MLAL = 2'h2,
        SVA_OP_NONE = 2'h3
    } sva_op_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SVA_ST_IDLE = 3'h1,
        SVA_ST_READ = 3'h2,
        SVA_ST_WRITE = 3'h4
    } sva_state_t;

    // All state of the top module
    typedef struct packed {
        sva_state_t st;
        sva_op_t op;
        logic [1:0] size;
        logic wide;
        logic uns;
        logic scalar;
        logic [1:0] idx;
        logic [`SVA_REG_NUM_W-1:0] rd_n;
        logic [`SVA_REG_NUM_W-1:0] rd_m;
        logic [`SVA_REG_NUM_W-1:0] dst;
        logic undef;
        logic trap;
        logic other;
        logic wb_valid;
        logic wb_pair;
        logic [`SVA_QREG_W-1:0] wb_data;
        logic sat_flag;
    } sva_regs_t;

endpackage

`default_nettype wire

// File: logic/sva_sat_word.sv
/*
 Saturating absolute value and saturating add over one 64-bit word,
 for every element width at once; the size code picks the result.
 Assumes purely combinational use by the top module, operands stable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sva_defs.svh"

module sva_sat_word
    import sva_pkg::*;
(
    // Operands: first source, second source (absolute value uses this one)
    input wire logic [`SVA_DREG_W-1:0] src_n,
    input wire logic [`SVA_DREG_W-1:0] src_m,
    // Controls
    input wire logic do_add,
    input wire logic is_unsigned,
    input wire logic [1:0] size,
    // Result word and any-element-saturated
    output logic [`SVA_DREG_W-1:0] res,
    output logic sat
);

    // Per size code: packed result word and saturation summary
    wire [`SVA_DREG_W-1:0] res_k [4];
    wire [3:0] sat_k;

    genvar k, e;
    generate
        for (k = 0; k < 4; k++)
        begin : g_size
            localparam int W = `SVA_ESIZE_BASE << k;
            localparam int N = `SVA_DREG_W / W;
            wire [N-1:0] esat;
            for (e = 0; e < N; e++)
            begin : g_elem
                wire [W-1:0] a = src_n[e*W +: W];
                wire [W-1:0] b = src_m[e*W +: W];
                wire [W-1:0] smax = {1'b0, {(W-1){1'b1}}};
                wire [W-1:0] smin = {1'b1, {(W-1){1'b0}}};
                // Only the most negative value has no positive twin
                wire abs_sat = (b == smin);
                wire [W-1:0] abs_res = abs_sat ? smax : (b[W-1] ? (~b + 1'b1) : b);
                // Full precision sums, one guard bit
                wire [W:0] sum_u = {1'b0, a} + {1'b0, b};
                wire [W:0] sum_s = {a[W-1], a} + {b[W-1], b};
                wire ovf_s = sum_s[W] ^ sum_s[W-1];
                // Signedness picks both reading and clamp range
                wire [W-1:0] add_u = sum_u[W] ? {W{1'b1}} : sum_u[W-1:0];
                wire [W-1:0] add_s = ovf_s ? (sum_s[W] ? smin : smax) : sum_s[W-1:0];
                wire [W-1:0] add_res = is_unsigned ? add_u : add_s;
                assign res_k[k][e*W +: W] = do_add ? add_res : abs_res;
                assign esat[e] = do_add ? (is_unsigned ? sum_u[W] : ovf_s) : abs_sat;
            end
            assign sat_k[k] = |esat;
        end
    endgenerate

    // Element width is eight shifted by the size code
    always_comb
    begin
        res = res_k[size];
        sat = sat_k[size];
    end

endmodule

`default_nettype wire

// File: logic/sva_arith_unit.sv
/*
 Saturating vector arithmetic unit: decode checks, register number
 forming, absolute value, add and doubling multiply-accumulate long,
 with a sticky cumulative saturation flag.
 Assumes a register file on the same clock that presents the addressed
 registers (as 128-bit pairs) combinationally during the read cycle,
 and writes back on the write-back pulse.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sva_defs.svh"

// What this block does
// - Absolute value per element, signed saturation
// - Size 00/01/10 signed widths, 11 undefined
// - Element width eight shifted by size field
// - Wide bit selects one or two registers
// - Wide form needs even register numbers
// - Add signedness bit picks range and reading
// - Add at full precision, then clamp
// - Any saturation sets the sticky flag
// - Register number is extension bit plus field
// - Access controls give undefined or hypervisor trap
// - Long form: size 11 other, 00 undefined
// - Doubled products accumulate into 128-bit destination
// - Scalar 16-bit: four elements, split index
// - Scalar 32-bit: two elements, index extension
// - Saturate doubled product then sum, flag both
module sva_arith_unit
    import sva_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Issue from instruction decode
    input wire logic issue_valid,
    input wire sva_op_t issue_op,
    input wire logic [1:0] issue_size,
    input wire logic issue_wide,
    input wire logic issue_unsigned,
    input wire logic issue_scalar,
    input wire logic [3:0] dest_reg_field,
    input wire logic dest_reg_hi,
    input wire logic [3:0] first_src_reg_field,
    input wire logic first_src_reg_hi,
    input wire logic [3:0] second_src_reg_field,
    input wire logic second_src_reg_hi,
    output logic issue_ready,
    // Access configuration and processor state
    input wire logic coproc_access_ctrl_en,
    input wire logic nonsecure_access_ctrl_en,
    input wire logic hyp_coproc_trap_ctrl_en,
    input wire logic secure_state,
    input wire logic hyp_mode,
    // Issue outcome pulses
    output logic undef_pulse,
    output logic hyp_trap_pulse,
    output logic other_enc_pulse,
    // Register file reads
    output logic [`SVA_REG_NUM_W-1:0] rd_n_addr,
    output logic [`SVA_REG_NUM_W-1:0] rd_m_addr,
    output logic [`SVA_REG_NUM_W-1:0] rd_d_addr,
    input wire logic [`SVA_QREG_W-1:0] rf_n_data,
    input wire logic [`SVA_QREG_W-1:0] rf_m_data,
    input wire logic [`SVA_QREG_W-1:0] rf_d_data,
    // Register file write-back
    output logic wb_valid,
    output logic wb_pair,
    output logic [`SVA_REG_NUM_W-1:0] wb_addr,
    output logic [`SVA_QREG_W-1:0] wb_data,
    // Status and control register flag
    input wire logic sat_flag_clear,
    output logic cumulative_saturation_flag
);

    // State register and its next value
    sva_regs_t s_q;
    sva_regs_t s_d;

    // Issue accepted this cycle
    wire accept = issue_valid && s_q.st[0];

    // Encoding checks on the raw issue fields
    wire is_abs = (issue_op == SVA_OP_ABS);
    wire is_add = (issue_op == SVA_OP_ADD);
    wire is_mlal = (issue_op == SVA_OP_MLAL);
    // Size 11 of the long form belongs to another instruction
    wire enc_other = is_mlal && (issue_size == `SVA_SIZE_B64);
    wire odd_dn = dest_reg_field[0] || second_src_reg_field[0];
    wire enc_undef_abs = is_abs && ((issue_size == `SVA_SIZE_B64) ||
                         (issue_wide && odd_dn));
    wire enc_undef_add = is_add && issue_wide && (odd_dn || first_src_reg_field[0]);
    wire enc_undef_mlal = is_mlal && ((issue_size == `SVA_SIZE_B8) || dest_reg_field[0]);
    wire enc_undef = enc_undef_abs || enc_undef_add || enc_undef_mlal ||
                     (issue_op == SVA_OP_NONE);

    // Access decision: lack of enable is undefined, hypervisor trap after
    wire access_undef = !coproc_access_ctrl_en || (!secure_state && !nonsecure_access_ctrl_en);
    wire access_trap = !secure_state && !hyp_mode && hyp_coproc_trap_ctrl_en;

    // Saturating absolute value and add, one instance per 64-bit word
    wire [`SVA_DREG_W-1:0] word_res [2];
    wire [1:0] word_sat;

    genvar r, k, e;
    generate
        for (r = 0; r < 2; r++)
        begin : g_word
            sva_sat_word u_word (
                .src_n(rf_n_data[r*`SVA_DREG_W +: `SVA_DREG_W]),
                .src_m(rf_m_data[r*`SVA_DREG_W +: `SVA_DREG_W]),
                .do_add(s_q.op == SVA_OP_ADD),
                .is_unsigned(s_q.uns),
                .size(s_q.size),
                .res(word_res[r]),
                .sat(word_sat[r])
            );
        end
    endgenerate

    // Doubling multiply-accumulate long, 16-bit (k=0) and 32-bit (k=1) lanes
    wire [`SVA_QREG_W-1:0] mla_res [2];
    wire [1:0] mla_sat;

    generate
        for (k = 0; k < 2; k++)
        begin : g_mla
            localparam int W = (`SVA_ESIZE_BASE * 2) << k;
            localparam int N = `SVA_DREG_W / W;
            wire [N-1:0] esat;
            // Scalar operand picked once by the stored index
            wire signed [W-1:0] scal = rf_m_data[s_q.idx*W +: W];
            for (e = 0; e < N; e++)
            begin : g_elem
                wire signed [W-1:0] a = rf_n_data[e*W +: W];
                wire signed [W-1:0] b = s_q.scalar ? scal : rf_m_data[e*W +: W];
                wire signed [2*W-1:0] acc = rf_d_data[e*2*W +: 2*W];
                wire [W-1:0] smin = {1'b1, {(W-1){1'b0}}};
                wire [2*W-1:0] dmax = {1'b0, {(2*W-1){1'b1}}};
                wire [2*W-1:0] dmin = {1'b1, {(2*W-1){1'b0}}};
                wire signed [2*W-1:0] prod = a * b;
                // Doubling overflows only for most negative times itself
                wire sat1 = (a == smin) && (b == smin);
                wire [2*W-1:0] dbl = sat1 ? dmax : {prod[2*W-2:0], 1'b0};
                wire [2*W:0] sum = {acc[2*W-1], acc} + {dbl[2*W-1], dbl};
                wire sat2 = sum[2*W] ^ sum[2*W-1];
                assign mla_res[k][e*2*W +: 2*W] = sat2 ? (sum[2*W] ? dmin : dmax) :
                                                  sum[2*W-1:0];
                assign esat[e] = sat1 || sat2;
            end
            assign mla_sat[k] = |esat;
        end
    endgenerate

    // Result and saturation of the operation held in the state
    wire mla_k1 = (s_q.size == `SVA_SIZE_B32);
    wire [`SVA_QREG_W-1:0] calc_data = (s_q.op == SVA_OP_MLAL) ? mla_res[mla_k1] :
        (s_q.wide ? {word_res[1], word_res[0]} : {64'h0, word_res[0]});
    wire calc_sat = (s_q.op == SVA_OP_MLAL) ? mla_sat[mla_k1] :
        (s_q.wide ? |word_sat : word_sat[0]);

    // Next state: sequencer, decode capture, result, sticky flag
    always_comb
    begin
        s_d = s_q;
        s_d.undef = 1'b0;
        s_d.trap = 1'b0;
        s_d.other = 1'b0;
        s_d.wb_valid = 1'b0;
        // Explicit clear first so that a saturation in the same cycle wins
        if (sat_flag_clear)
        begin
            s_d.sat_flag = 1'b0;
        end
        unique case (s_q.st)
            SVA_ST_IDLE:
            begin
                if (issue_valid)
                begin
                    s_d.op = issue_op;
                    s_d.size = issue_size;
                    s_d.wide = issue_wide;
                    s_d.uns = issue_unsigned;
                    s_d.scalar = issue_scalar && is_mlal;
                    s_d.idx = 2'h0;
                    // Extension bit joined to the field
                    s_d.rd_n = {first_src_reg_hi, first_src_reg_field};
                    s_d.rd_m = {second_src_reg_hi, second_src_reg_field};
                    s_d.dst = {dest_reg_hi, dest_reg_field};
                    if (is_mlal && issue_scalar)
                    begin
                        if (issue_size == `SVA_SIZE_B16)
                        begin
                            // Low three bits name the register
                            s_d.rd_m = {2'h0, second_src_reg_field[2:0]};
                            s_d.idx = {second_src_reg_hi, second_src_reg_field[3]};
                        end
                        else
                        begin
                            // Full field names the register
                            s_d.rd_m = {1'b0, second_src_reg_field};
                            s_d.idx = {1'b0, second_src_reg_hi};
                        end
                    end
                    // Encoding faults come before the access check
                    if (enc_other)
                    begin
                        s_d.other = 1'b1;
                    end
                    else if (enc_undef || access_undef)
                    begin
                        s_d.undef = 1'b1;
                    end
                    else if (access_trap)
                    begin
                        s_d.trap = 1'b1;
                    end
                    else
                    begin
                        s_d.st = SVA_ST_READ;
                    end
                end
            end
            SVA_ST_READ:
            begin
                // Operands are on the read ports now; result goes out next
                s_d.wb_data = calc_data;
                s_d.wb_pair = s_q.wide || (s_q.op == SVA_OP_MLAL);
                s_d.wb_valid = 1'b1;
                if (calc_sat)
                begin
                    s_d.sat_flag = 1'b1;
                end
                s_d.st = SVA_ST_WRITE;
            end
            SVA_ST_WRITE:
            begin
                // One idle beat lets the file commit before the next read
                s_d.st = SVA_ST_IDLE;
            end
            default:
            begin
                // Recover from a broken one-hot code
                s_d.st = SVA_ST_IDLE;
            end
        endcase
    end

    // State register; apart from reset, only sat_flag_clear ever lowers the flag
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.st <= sva_state_t'(`SVA_STATE_RST);
            s_q.sat_flag <= `SVA_FLAG_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign issue_ready = s_q.st[0];
    assign undef_pulse = s_q.undef;
    assign hyp_trap_pulse = s_q.trap;
    assign other_enc_pulse = s_q.other;
    assign rd_n_addr = s_q.rd_n;
    assign rd_m_addr = s_q.rd_m;
    assign rd_d_addr = s_q.dst;
    assign wb_valid = s_q.wb_valid;
    assign wb_pair = s_q.wb_pair;
    assign wb_addr = s_q.dst;
    assign wb_data = s_q.wb_data;
    assign cumulative_saturation_flag = s_q.sat_flag;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    wire in_read = s_q.st[1];

    property p_abs_min8;
        (in_read && s_q.op == SVA_OP_ABS && s_q.size == `SVA_SIZE_B8 &&
         rf_m_data[7:0] == 8'h80) |=> (wb_data[7:0] == 8'h7F) && cumulative_saturation_flag;
    endproperty
    a_abs_min8: assert property (p_abs_min8) else $error("abs of min byte not clamped");

    property p_abs_size_rsv;
        (accept && is_abs && issue_size == `SVA_SIZE_B64) |=> undef_pulse ##0 !wb_valid [*2];
    endproperty
    a_abs_size_rsv: assert property (p_abs_size_rsv) else $error("reserved size ran");

    property p_abs_min32;
        (in_read && s_q.op == SVA_OP_ABS && s_q.size == `SVA_SIZE_B32 &&
         rf_m_data[31:0] == 32'h80000000) |=> wb_data[31:0] == 32'h7FFFFFFF;
    endproperty
    a_abs_min32: assert property (p_abs_min32) else $error("32-bit lane width wrong");

    property p_narrow_single;
        (in_read && !s_q.wide && s_q.op != SVA_OP_MLAL) |=> wb_valid && !wb_pair;
    endproperty
    a_narrow_single: assert property (p_narrow_single) else $error("narrow wrote a pair");

    property p_wide_odd;
        (accept && is_add && issue_wide && first_src_reg_field[0]) |=> undef_pulse;
    endproperty
    a_wide_odd: assert property (p_wide_odd) else $error("odd wide register accepted");

    property p_add_u16;
        (in_read && s_q.op == SVA_OP_ADD && s_q.uns && s_q.size == `SVA_SIZE_B16 &&
         ({1'b0, rf_n_data[15:0]} + {1'b0, rf_m_data[15:0]}) > 17'h0FFFF)
        |=> (wb_data[15:0] == 16'hFFFF) && cumulative_saturation_flag;
    endproperty
    a_add_u16: assert property (p_add_u16) else $error("unsigned add not clamped");

    property p_flag_rise;
        $rose(cumulative_saturation_flag) |-> wb_valid;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag set without result");

    property p_flag_hold;
        (cumulative_saturation_flag && !sat_flag_clear) |=> cumulative_saturation_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself");

    property p_reg_num;
        (accept && is_add) |=> rd_n_addr == {$past(first_src_reg_hi), $past(first_src_reg_field)};
    endproperty
    a_reg_num: assert property (p_reg_num) else $error("register number misformed");

    property p_access;
        (accept && !enc_other && !coproc_access_ctrl_en) |=> undef_pulse && !hyp_trap_pulse;
    endproperty
    a_access: assert property (p_access) else $error("disabled access not undefined");

    property p_mlal_size0;
        (accept && is_mlal && issue_size == `SVA_SIZE_B8) |=> undef_pulse ##1 !wb_valid;
    endproperty
    a_mlal_size0: assert property (p_mlal_size0) else $error("long form size 00 ran");

    property p_mlal_sat;
        (in_read && s_q.op == SVA_OP_MLAL && s_q.size == `SVA_SIZE_B16 && !s_q.scalar &&
         rf_n_data[15:0] == 16'h8000 && rf_m_data[15:0] == 16'h8000 && !rf_d_data[31])
        |=> (wb_data[31:0] == 32'h7FFFFFFF) && cumulative_saturation_flag && wb_pair;
    endproperty
    a_mlal_sat: assert property (p_mlal_sat) else $error("doubled product not clamped");

    property p_scalar16;
        (accept && is_mlal && issue_scalar && issue_size == `SVA_SIZE_B16)
        |=> rd_m_addr == {2'h0, $past(second_src_reg_field[2:0])};
    endproperty
    a_scalar16: assert property (p_scalar16) else $error("scalar register misformed");

    c_abs_sat: cover property (in_read && s_q.op == SVA_OP_ABS ##1 cumulative_saturation_flag);
    c_add_wide: cover property (in_read && s_q.op == SVA_OP_ADD && s_q.wide ##1 wb_valid);
    c_mlal_scalar: cover property (in_read && s_q.op == SVA_OP_MLAL && s_q.scalar ##1 wb_valid);
    c_trap: cover property (hyp_trap_pulse);

endmodule

`default_nettype wire

// File: verif/sva_rf_model.sv
/*
 Register file model facing the saturating vector arithmetic unit.
 Assumes the bench preloads mem by name between clock edges.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sva_defs.svh"

module sva_rf_model
(
    // Clock
    input wire logic clk_sys,
    // Read addresses from the unit
    input wire logic [`SVA_REG_NUM_W-1:0] rd_n_addr,
    input wire logic [`SVA_REG_NUM_W-1:0] rd_m_addr,
    input wire logic [`SVA_REG_NUM_W-1:0] rd_d_addr,
    // Read data, register N low and N+1 high
    output logic [`SVA_QREG_W-1:0] rf_n_data,
    output logic [`SVA_QREG_W-1:0] rf_m_data,
    output logic [`SVA_QREG_W-1:0] rf_d_data,
    // Write-back from the unit
    input wire logic wb_valid,
    input wire logic wb_pair,
    input wire logic [`SVA_REG_NUM_W-1:0] wb_addr,
    input wire logic [`SVA_QREG_W-1:0] wb_data
);
    // Thirty-two 64-bit registers
    logic [63:0] mem [0:31];

    // Reads are combinational so the read cycle always sees fresh data
    always_comb
    begin
        rf_n_data = {mem[rd_n_addr + 5'h01], mem[rd_n_addr]};
        rf_m_data = {mem[rd_m_addr + 5'h01], mem[rd_m_addr]};
        rf_d_data = {mem[rd_d_addr + 5'h01], mem[rd_d_addr]};
    end

    // Commit on the pulse edge; the upper half only for a pair
    always @(posedge clk_sys)
    begin
        if (wb_valid)
        begin
            mem[wb_addr] <= wb_data[63:0];
            if (wb_pair)
            begin
                mem[wb_addr + 5'h01] <= wb_data[127:64];
            end
        end
    end
endmodule

`default_nettype wire

// File: verif/saturating_vector_arith_tb.sv
/*
 Self-checking bench of the saturating vector arithmetic unit.
 Assumes the register file model sits on the far side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sva_defs.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin miscompares++; \
    $display("Error %s exp %h got %h", nm, ex, gt); end end

module saturating_vector_arith_tb;
    import sva_pkg::*;
    // Stimulus
    logic clk_sys = 1'b0, resetn = 1'b0, issue_valid = 1'b0, sat_flag_clear = 1'b0;
    logic issue_wide = 1'b0, issue_unsigned = 1'b0, issue_scalar = 1'b0;
    sva_op_t issue_op = SVA_OP_NONE;
    logic [1:0] issue_size = 2'h0;
    logic [4:0] dr = 5'h00, nr = 5'h00, mr = 5'h00, acc = 5'h1A, a_cfg = 5'h1A;
    // Unit outputs and register file lines
    logic issue_ready, undef_pulse, hyp_trap_pulse, other_enc_pulse, wb_valid, wb_pair, flag;
    logic [4:0] rd_n_addr, rd_m_addr, rd_d_addr, wb_addr;
    logic [127:0] rf_n_data, rf_m_data, rf_d_data, wb_data;
    // Captured answer: pulses {other, undef, trap}, write-back
    logic [2:0] g_p;
    logic g_wb, g_pair;
    logic [4:0] g_addr, g_m;
    logic [127:0] g_data;
    int miscompares = 0, num_checks = 0;

    always #10 clk_sys = ~clk_sys;

    sva_arith_unit dut_u (.clk_sys(clk_sys), .resetn(resetn), .issue_valid(issue_valid),
        .issue_op(issue_op), .issue_size(issue_size), .issue_wide(issue_wide),
        .issue_unsigned(issue_unsigned), .issue_scalar(issue_scalar),
        .dest_reg_field(dr[3:0]), .dest_reg_hi(dr[4]), .first_src_reg_field(nr[3:0]),
        .first_src_reg_hi(nr[4]), .second_src_reg_field(mr[3:0]),
        .second_src_reg_hi(mr[4]), .issue_ready(issue_ready),
        .coproc_access_ctrl_en(acc[4]), .nonsecure_access_ctrl_en(acc[3]),
        .hyp_coproc_trap_ctrl_en(acc[2]), .secure_state(acc[1]), .hyp_mode(acc[0]),
        .undef_pulse(undef_pulse), .hyp_trap_pulse(hyp_trap_pulse),
        .other_enc_pulse(other_enc_pulse), .rd_n_addr(rd_n_addr), .rd_m_addr(rd_m_addr),
        .rd_d_addr(rd_d_addr), .rf_n_data(rf_n_data), .rf_m_data(rf_m_data),
        .rf_d_data(rf_d_data), .wb_valid(wb_valid), .wb_pair(wb_pair), .wb_addr(wb_addr),
        .wb_data(wb_data), .sat_flag_clear(sat_flag_clear),
        .cumulative_saturation_flag(flag));

    sva_rf_model rf_u (.clk_sys(clk_sys), .rd_n_addr(rd_n_addr), .rd_m_addr(rd_m_addr),
        .rd_d_addr(rd_d_addr), .rf_n_data(rf_n_data), .rf_m_data(rf_m_data),
        .rf_d_data(rf_d_data), .wb_valid(wb_valid), .wb_pair(wb_pair), .wb_addr(wb_addr),
        .wb_data(wb_data));

    // One request; only the unconditional form exists at these ports
    task automatic issue(input sva_op_t op, input logic [1:0] sz, input logic [2:0] f,
        input logic [4:0] d, input logic [4:0] n, input logic [4:0] m);
    begin
        @(posedge clk_sys);
        issue_valid <= 1'b1;
        issue_op <= op;
        issue_size <= sz;
        {issue_wide, issue_unsigned, issue_scalar} <= f;
        {dr, nr, mr} <= {d, n, m};
        acc <= a_cfg;
        // Unit is idle here, so this edge takes it
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        #1;
        g_p = {other_enc_pulse, undef_pulse, hyp_trap_pulse};
        g_m = rd_m_addr;
        @(posedge clk_sys);
        #1;
        {g_wb, g_pair, g_addr, g_data} = {wb_valid, wb_pair, wb_addr, wb_data};
        // Let the register file commit before the caller preloads it again
        @(posedge clk_sys);
        #1;
    end
    endtask

    // Faulting or access-gated request: expected pulse set, write only when none
    task automatic flt(input sva_op_t op, input logic [1:0] sz, input logic [2:0] f,
        input logic [4:0] d, input logic [4:0] n, input logic [4:0] m,
        input logic [4:0] a, input logic [2:0] ex);
    begin
        a_cfg = a;
        issue(op, sz, f, d, n, m);
        `CHK("outcome", ex, g_p)
        `CHK("write", (ex == 3'b000), g_wb)
        a_cfg = 5'h1A;
    end
    endtask

    task automatic t_abs;
    begin
        rf_u.mem[0] = 64'h0000_0000_F080_0080;
        issue(SVA_OP_ABS, 2'h0, 3'b000, 5'h01, 5'h00, 5'h00);
        `CHK("abs8", {64'h0, 64'h0000_0000_107F_007F}, g_data)
        `CHK("flag", 1'b1, flag)
        $display("test abs done");
    end
    endtask

    task automatic t_add;
        logic u;
    begin
        rf_u.mem[6] = 64'hFF7F;
        rf_u.mem[7] = 64'h0101;
        for (int i = 0; i < 2; i++)
        begin
            u = i[0];
            issue(SVA_OP_ADD, 2'h0, {1'b0, u, 1'b0}, 5'h08, 5'h06, 5'h07);
            `CHK("add8", (u ? 64'hFF80 : 64'h007F), g_data[63:0])
        end
        $display("test add done");
    end
    endtask

    task automatic t_mlal;
    begin
        rf_u.mem[8] = 64'h0003_8000;
        rf_u.mem[9] = 64'h0002_8000;
        rf_u.mem[10] = 64'h5;
        rf_u.mem[11] = 64'h0;
        issue(SVA_OP_MLAL, 2'h1, 3'b000, 5'h0A, 5'h08, 5'h09);
        `CHK("mlal", {64'h0, 64'h0000_000C_7FFF_FFFF}, g_data)
        `CHK("pair", 1'b1, g_pair)
        // Scalar 32-bit: register 13, element 1 = 4
        rf_u.mem[12] = 64'h0000_0002_0000_0003;
        rf_u.mem[13] = 64'h0000_0004_0000_0000;
        rf_u.mem[14] = 64'h1;
        rf_u.mem[15] = 64'h0;
        issue(SVA_OP_MLAL, 2'h2, 3'b001, 5'h0E, 5'h0C, 5'h1D);
        `CHK("scal32", {64'h10, 64'h19}, g_data)
        `CHK("scal32 reg", 5'h0D, g_m)
        // Scalar 16-bit: field 1011, hi 1 gives register 3, element 3 = 5
        rf_u.mem[3] = 64'h0005_0000_0000_0000;
        rf_u.mem[16] = 64'h0;
        rf_u.mem[17] = 64'h0;
        issue(SVA_OP_MLAL, 2'h1, 3'b001, 5'h10, 5'h0C, 5'h1B);
        `CHK("scal16", {64'h14, 64'h1E}, g_data)
        `CHK("scal16 reg", 5'h03, g_m)
        `CHK("flag kept", 1'b1, flag)
        $display("test mlal done");
    end
    endtask

    task automatic t_clear;
    begin
        @(posedge clk_sys);
        sat_flag_clear <= 1'b1;
        @(posedge clk_sys);
        sat_flag_clear <= 1'b0;
        rf_u.mem[2] = 64'h0001_FFFE_0003_7FFF;
        rf_u.mem[3] = 64'hFFFF_0000_0000_0000;
        issue(SVA_OP_ABS, 2'h1, 3'b100, 5'h14, 5'h00, 5'h02);
        `CHK("abs wide", {64'h0001_0000_0000_0000, 64'h0001_0002_0003_7FFF}, g_data)
        `CHK("wide pair", 1'b1, g_pair)
        `CHK("wb reg", 5'h14, g_addr)
        `CHK("flag clear", 1'b0, flag)
        $display("test clear done");
    end
    endtask

    task automatic t_faults;
    begin
        flt(SVA_OP_ABS, 2'h3, 3'b000, 5'h00, 5'h00, 5'h00, 5'h1A, 3'b010);
        flt(SVA_OP_NONE, 2'h0, 3'b000, 5'h00, 5'h00, 5'h00, 5'h1A, 3'b010);
        flt(SVA_OP_ABS, 2'h0, 3'b100, 5'h03, 5'h00, 5'h02, 5'h1A, 3'b010);
        flt(SVA_OP_ADD, 2'h1, 3'b100, 5'h02, 5'h05, 5'h04, 5'h1A, 3'b010);
        flt(SVA_OP_MLAL, 2'h0, 3'b000, 5'h02, 5'h00, 5'h00, 5'h1A, 3'b010);
        flt(SVA_OP_MLAL, 2'h3, 3'b000, 5'h02, 5'h00, 5'h00, 5'h1A, 3'b100);
        flt(SVA_OP_MLAL, 2'h1, 3'b000, 5'h03, 5'h00, 5'h00, 5'h1A, 3'b010);
        flt(SVA_OP_ADD, 2'h0, 3'b000, 5'h00, 5'h00, 5'h00, 5'h0A, 3'b010);
        flt(SVA_OP_ADD, 2'h0, 3'b000, 5'h00, 5'h00, 5'h00, 5'h10, 3'b010);
        flt(SVA_OP_ADD, 2'h0, 3'b000, 5'h00, 5'h00, 5'h00, 5'h1C, 3'b001);
        flt(SVA_OP_ADD, 2'h0, 3'b000, 5'h00, 5'h00, 5'h00, 5'h1D, 3'b000);
        $display("test faults done");
    end
    endtask

    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // Watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        miscompares++;
        report_and_stop;
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        `CHK("ready", 1'b1, issue_ready)
        t_abs;
        t_add;
        t_mlal;
        t_clear;
        t_faults;
        report_and_stop;
    end
endmodule

`default_nettype wire
